// [imf_pkg.sv]
// Purpose: Shared constants for the inverse-multiplexing frame builder
// Assumes: One 10 MHz clock, synchronous active-low reset
// Notes:   Cell fields are octet-indexed, octet 1 first
package imf_pkg;
    localparam int          CELL_OCTETS      = 53;
    localparam logic [7:0]  OAM_LABEL_V      = 8'h03;
    localparam int          OCT_LABEL        = 6;
    localparam int          OCT_LINK         = 7;
    localparam int          OCT_SEQ          = 8;
    localparam int          OCT_OFFSET       = 9;
    localparam int          OCT_STATUS       = 11;
    localparam int          OCT_FRAME_LEN    = 10;
    localparam int          OCT_UNUSED       = 50;
    localparam int          OCT_E2E          = 51;
    localparam int          CTYPE_BIT        = 7;
    localparam int          LINK_ID_MSB      = 4;
    localparam logic [7:0]  UNUSED_FILL_V    = 8'h6a;
    localparam logic [7:0]  SEQ_RESET_V      = 8'h00;
    localparam logic [8:0]  M_DEFAULT        = 9'h080;
    localparam logic [1:0]  MCODE_32         = 2'h0;
    localparam logic [1:0]  MCODE_64         = 2'h1;
    localparam logic [1:0]  MCODE_128        = 2'h2;
    localparam logic [1:0]  MCODE_256        = 2'h3;
    localparam logic [2:0]  STAT_OPERATIONAL = 3'h1;
    localparam logic [2:0]  STAT_ABORT_VER   = 3'h5;
    localparam logic [7:0]  SUPPORTED_VER    = 8'h03;
    typedef enum logic [1:0] {CT_USER, CT_FILLER, CT_CONTROL} imf_cell_t;
endpackage

// [imf_fifo.sv]
// Purpose: Small valid/ready FIFO for queued user cell tokens
// Assumes: Single clock, synchronous active-low reset
// Notes:   Depth must be a power of two
module imf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wr_reg;
    logic [AW:0]      rd_reg;
    logic             push;
    logic             pop;

    assign in_ready  = (wr_reg - rd_reg) != (AW+1)'(DEPTH);
    assign out_valid = wr_reg != rd_reg;
    assign out_data  = mem[rd_reg[AW-1:0]];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_reg <= '0;
        end else if (push) begin
            wr_reg <= wr_reg + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rd_reg <= '0;
        end else if (pop) begin
            rd_reg <= rd_reg + 1'b1;
        end
    end
endmodule

// [imf_framer.sv]
// Purpose: Per-link frame builder with control cell insertion and checks
// Assumes: REF_CLK 10 MHz; one cell slot per CELL_TICK pulse on all links
// Notes:   Each link emits one cell descriptor per slot, octets built here
// Function
// [RULE1] End-to-end channel never steers behaviour
// [RULE2] Act only on header and CRC clean cells
// [RULE3] Label octet always 0x03 on sent cells
// [RULE4] Unsupported far version reports aborted status
// [RULE5] Continuous frames of exactly M cells
// [RULE6] One control cell per frame per link
// [RULE7] Sequence number wraps 255 to 0
// [RULE8] Sequence advances once per frame
// [RULE9] Same sequence number on all links
// [RULE10] Frame boundaries aligned across links
// [RULE11] Octet 9 carries control cell position
// [RULE12] Position always within 0 to M-1
// [RULE13] Positions spread evenly across links
// [RULE14] Position chosen when link identifier assigned
// [RULE15] Position fixed while link stays member
// [RULE16] Frame length field reports M
// [RULE17] Frame length 128 supported
// [RULE18] Frame lengths 32, 64, 256 supported
// [RULE19] Octet 7 low bits carry link identifier
// [RULE20] Octet 7 bit 7 marks cell type
// [RULE21] Empty slots carry user or filler cell
module imf_framer #(
    parameter int LINKS = 4,
    parameter int QW    = 8,
    parameter int QD    = 4
) (
    input  wire logic                REF_CLK,
    input  wire logic                RST_N,
    input  wire logic                CELL_TICK,
    input  wire logic [1:0]          M_CODE,
    input  wire logic [LINKS-1:0]    LINK_MEMBER,
    input  wire logic [LINKS*5-1:0]  LINK_ID,
    input  wire logic                USER_VALID,
    output logic                     USER_READY,
    input  wire logic [QW-1:0]       USER_DATA,
    input  wire logic                RX_VALID,
    input  wire logic                RX_HEC_OK,
    input  wire logic                RX_CRC_OK,
    input  wire logic                RX_IS_CONTROL,
    input  wire logic [7:0]          RX_LABEL,
    input  wire logic [7:0]          RX_E2E,
    output logic                     TX_VALID,
    output logic [LINKS*2-1:0]       TX_KIND,
    output logic [LINKS*QW-1:0]      TX_USER,
    output logic [LINKS*8-1:0]       TX_OCT7,
    output logic [7:0]               TX_LABEL,
    output logic [7:0]               TX_SEQ,
    output logic [7:0]               TX_OFFSET,
    output logic [7:0]               TX_FRAME_LEN,
    output logic [7:0]               TX_STATUS,
    output logic [7:0]               TX_UNUSED,
    output logic [7:0]               TX_E2E
);
    // M is sampled only at reset-release; later M_CODE changes are ignored until the next reset
    logic [1:0]       mcode_reg;
    logic [8:0]       m_len;
    logic [7:0]       slot_reg;
    logic [7:0]       seq_reg;
    logic             abort_reg;
    logic             started_reg;
    logic [LINKS-1:0] member_reg;
    logic [7:0]       offset_reg [LINKS];
    logic [7:0]       frame_len_code;
    logic             q_valid;
    logic             q_ready;
    logic [QW-1:0]    q_data;
    logic [LINKS-1:0] want_user;
    logic [LINKS-1:0] grant;
    logic             last_slot;

    function automatic logic [8:0] m_of(input logic [1:0] c);
        unique case (c)
            imf_pkg::MCODE_32:  m_of = 9'h020;
            imf_pkg::MCODE_64:  m_of = 9'h040;
            imf_pkg::MCODE_128: m_of = imf_pkg::M_DEFAULT;
            imf_pkg::MCODE_256: m_of = 9'h100;
        endcase
    endfunction

    assign m_len          = m_of(mcode_reg); // see [RULE17] see [RULE18]
    assign last_slot      = slot_reg == 8'(m_len - 9'h001);
    assign frame_len_code = {6'h00, mcode_reg}; // see [RULE16]

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            mcode_reg <= imf_pkg::MCODE_128;
        end else if (!started_reg) begin
            mcode_reg <= M_CODE;
        end
    end

    // One shared slot counter keeps every link on the same boundary
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            slot_reg <= 8'h00;
        end else if (started_reg && CELL_TICK) begin
            slot_reg <= last_slot ? 8'h00 : slot_reg + 8'h01; // see [RULE5] see [RULE10]
        end
    end

    // Shared count; advanced once per frame, identical on each link
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            seq_reg <= imf_pkg::SEQ_RESET_V;
        end else if (started_reg && CELL_TICK && last_slot) begin
            seq_reg <= seq_reg + 8'h01; // see [RULE7] see [RULE8] see [RULE9]
        end
    end

    // Far-end version check; end-to-end octet deliberately not read
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            abort_reg <= 1'b0;
        end else if (RX_VALID && RX_HEC_OK && RX_CRC_OK && RX_IS_CONTROL) begin // see [RULE2] see [RULE1]
            abort_reg <= RX_LABEL != imf_pkg::SUPPORTED_VER; // see [RULE4]
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            member_reg <= '0;
        end else begin
            member_reg <= LINK_MEMBER;
        end
    end

    genvar g;
    generate
        for (g = 0; g < LINKS; g++) begin : g_link
            logic [7:0] link_identifier;
            logic       ctl;
            assign link_identifier = {3'h0, LINK_ID[g*5 +: 5]};
            assign ctl = slot_reg == offset_reg[g];
            // Spread: id times M/32, always below M
            always_ff @(posedge REF_CLK) begin
                if (!RST_N) begin
                    offset_reg[g] <= 8'h00;
                end else if (LINK_MEMBER[g] && !member_reg[g]) begin // see [RULE14] see [RULE15]
                    offset_reg[g] <= 8'((link_identifier * 16'(m_len)) >> 5); // see [RULE12] see [RULE13]
                end
            end
            assign want_user[g] = !ctl && LINK_MEMBER[g];
            always_ff @(posedge REF_CLK) begin
                if (!RST_N) begin
                    TX_KIND[g*2 +: 2] <= 2'(imf_pkg::CT_FILLER);
                    TX_USER[g*QW +: QW] <= '0;
                    TX_OCT7[g*8 +: 8] <= 8'h00;
                end else if (started_reg && CELL_TICK) begin
                    // see [RULE6] see [RULE21]
                    TX_KIND[g*2 +: 2] <= ctl ? 2'(imf_pkg::CT_CONTROL) :
                        (grant[g] ? 2'(imf_pkg::CT_USER) : 2'(imf_pkg::CT_FILLER));
                    TX_USER[g*QW +: QW] <= grant[g] ? q_data : '0;
                    TX_OCT7[g*8 +: 8] <= {ctl, 2'h0, link_identifier[4:0]}; // see [RULE19] see [RULE20]
                end
            end
        end
    endgenerate

    // Only the lowest user-wanting link takes the head cell each slot
    always_comb begin
        grant = '0;
        for (int i = 0; i < LINKS; i++) begin
            if (want_user[i] && q_valid && grant == '0) begin
                grant[i] = 1'b1;
            end
        end
    end
    assign q_ready = started_reg && CELL_TICK && (grant != '0);

    imf_fifo #(
        .WIDTH(QW),
        .DEPTH(QD)
    ) u_queue (
        .clk      (REF_CLK),
        .rst_n    (RST_N),
        .in_valid (USER_VALID),
        .in_ready (USER_READY),
        .in_data  (USER_DATA),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data (q_data)
    );

    // Shared fields are common to all links for the slot just sent
    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            TX_VALID     <= 1'b0;
            TX_LABEL     <= imf_pkg::OAM_LABEL_V;
            TX_SEQ       <= imf_pkg::SEQ_RESET_V;
            TX_OFFSET    <= 8'h00;
            TX_FRAME_LEN <= 8'h00;
            TX_STATUS    <= 8'h00;
            TX_UNUSED    <= imf_pkg::UNUSED_FILL_V;
            TX_E2E       <= 8'h00;
        end else begin
            TX_VALID <= started_reg && CELL_TICK;
            if (started_reg && CELL_TICK) begin
                TX_LABEL     <= imf_pkg::OAM_LABEL_V; // see [RULE3]
                TX_SEQ       <= seq_reg;
                TX_OFFSET    <= slot_reg; // see [RULE11]
                TX_FRAME_LEN <= frame_len_code; // see [RULE16]
                TX_STATUS    <= {5'h00, abort_reg ? imf_pkg::STAT_ABORT_VER
                                                  : imf_pkg::STAT_OPERATIONAL}; // see [RULE4]
                TX_E2E       <= 8'h00;
            end
        end
    end

    a_frame_wrap: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE5]
        (started_reg && CELL_TICK && last_slot) |=> slot_reg == 8'h00)
        else $error("slot did not wrap at M");
    a_seq_step: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE8]
        (started_reg && CELL_TICK && last_slot) |=> seq_reg == $past(seq_reg) + 8'h01)
        else $error("sequence not advanced at frame end");
    a_seq_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE8]
        !(CELL_TICK && last_slot) |=> $stable(seq_reg))
        else $error("sequence moved inside frame");
    a_label_fixed: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE3]
        TX_VALID |-> TX_LABEL == 8'h03)
        else $error("label not 0x03");
    a_offset_range: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE12]
        9'(offset_reg[0]) < m_len)
        else $error("offset out of frame");
    a_offset_keep: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE15]
        (member_reg[0] && LINK_MEMBER[0]) |=> $stable(offset_reg[0]))
        else $error("offset changed while member");
    a_ctl_once: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE6]
        (started_reg && CELL_TICK && slot_reg == offset_reg[0])
        |=> TX_KIND[1:0] == 2'(imf_pkg::CT_CONTROL) && TX_OCT7[7])
        else $error("control cell missing at offset");
    a_abort_status: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE4]
        (RX_VALID && RX_HEC_OK && RX_CRC_OK && RX_IS_CONTROL && RX_LABEL != 8'h03
         && started_reg && CELL_TICK) ##1 (started_reg && CELL_TICK)
        |=> TX_STATUS[2:0] == imf_pkg::STAT_ABORT_VER)
        else $error("abort status not sent");
    a_bad_ignored: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE2]
        (RX_VALID && !(RX_HEC_OK && RX_CRC_OK)) |=> $stable(abort_reg))
        else $error("errored cell acted upon");

    // Steps shared by the field checks below
    sequence s_clean_ctl;
        RX_VALID && RX_HEC_OK && RX_CRC_OK && RX_IS_CONTROL;
    endsequence

    sequence s_tick;
        started_reg && CELL_TICK;
    endsequence

    sequence s_wrap_tick;
        started_reg && CELL_TICK && last_slot && seq_reg == 8'hff;
    endsequence

    // Status path: latch on a clean cell, report on the next slot
    a_abort_set: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE4]
        (s_clean_ctl ##0 RX_LABEL != imf_pkg::SUPPORTED_VER) |=> abort_reg)
        else $error("bad version not latched");
    a_abort_clear: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE4]
        (s_clean_ctl ##0 RX_LABEL == imf_pkg::SUPPORTED_VER) |=> !abort_reg)
        else $error("good version not cleared");
    a_abort_sent: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE4]
        (abort_reg ##0 s_tick) |=> TX_STATUS[2:0] == imf_pkg::STAT_ABORT_VER)
        else $error("aborted status missing");
    a_ok_sent: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE4]
        (!abort_reg ##0 s_tick) |=> TX_STATUS[2:0] == imf_pkg::STAT_OPERATIONAL)
        else $error("operational status missing");
    a_ctl_only: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE2]
        (RX_VALID && !RX_IS_CONTROL) |=> $stable(abort_reg))
        else $error("non-control cell acted upon");

    // Slot timing and shared fields
    a_tx_pulse: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE5]
        s_tick |=> TX_VALID)
        else $error("tick not answered");
    a_tx_idle: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE5]
        !(started_reg && CELL_TICK) |=> !TX_VALID)
        else $error("cell sent without tick");
    a_slot_hold: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE10]
        !(started_reg && CELL_TICK) |=> $stable(slot_reg))
        else $error("slot moved without tick");
    a_slot_range: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE12]
        9'(slot_reg) < m_len)
        else $error("slot beyond frame");
    a_seq_wrap: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE7]
        s_wrap_tick |=> seq_reg == 8'h00)
        else $error("sequence did not wrap");
    a_offset_field: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE11]
        s_tick |=> TX_OFFSET == $past(slot_reg))
        else $error("offset field wrong");
    a_seq_field: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE9]
        s_tick |=> TX_SEQ == $past(seq_reg))
        else $error("sequence field wrong");
    a_mcode_frozen: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE17]
        started_reg |=> $stable(mcode_reg))
        else $error("frame length changed mid-run");
    a_e2e_zero: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE1]
        TX_E2E == 8'h00)
        else $error("end-to-end octet not zero");
    a_unused_fixed: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE3]
        TX_UNUSED == imf_pkg::UNUSED_FILL_V)
        else $error("unused octet wrong");
    a_grant_single: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE21]
        $onehot0(grant))
        else $error("head cell granted twice");
    a_pop_valid: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE21]
        q_ready |-> q_valid)
        else $error("pop from empty queue");

    // Per-link checks; every link, not only the first
    genvar h;
    generate
        for (h = 0; h < LINKS; h++) begin : g_chk
            a_link_ctl: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE6]
                (s_tick ##0 slot_reg == offset_reg[h])
                |=> TX_KIND[h*2 +: 2] == 2'(imf_pkg::CT_CONTROL))
                else $error("link control cell missing");
            a_link_noctl: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE6]
                (s_tick ##0 slot_reg != offset_reg[h])
                |=> TX_KIND[h*2 +: 2] != 2'(imf_pkg::CT_CONTROL))
                else $error("extra link control cell");
            a_link_range: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE12]
                9'(offset_reg[h]) < m_len)
                else $error("link offset beyond frame");
            a_link_ident: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE19]
                s_tick |=> TX_OCT7[h*8 +: 5] == $past(LINK_ID[h*5 +: 5]))
                else $error("link identifier wrong");
            a_link_flag: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE20]
                s_tick |=> TX_OCT7[h*8+7] == $past(slot_reg == offset_reg[h]))
                else $error("cell type bit wrong");
            a_link_user: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE21]
                (s_tick ##0 grant[h]) |=> TX_USER[h*QW +: QW] == $past(q_data))
                else $error("user cell data wrong");
            a_link_filler: assert property (@(posedge REF_CLK) disable iff (!RST_N) // see [RULE21]
                (s_tick ##0 !grant[h]) |=> TX_USER[h*QW +: QW] == '0)
                else $error("filler carries data");
        end
    endgenerate
endmodule

// [imf_far_end.sv]
// Purpose: Far-end unit model that sends received control cells
// Assumes: Bench holds send and fields across one REF_CLK rising edge
// Notes:   Idle fields toggle so a stale cell never looks valid
module imf_far_end (
    input  wire logic       clk,
    input  wire logic       send,
    input  wire logic [2:0] flags,
    input  wire logic [7:0] label,
    output logic            rx_valid = 1'b0,
    output logic      [2:0] rx_flags = 3'h0,
    output logic      [7:0] rx_label = 8'h00,
    output logic      [7:0] rx_e2e   = 8'h00
);
    always @(posedge clk) begin
        rx_valid <= send;
        rx_e2e   <= rx_e2e + 8'h3b;     // Junk channel contents
        if (send) begin
            rx_flags <= flags;          // Header ok, payload ok, type bit
            rx_label <= label;
        end else begin
            rx_flags <= ~rx_flags;
            rx_label <= ~rx_label;
        end
    end
endmodule

// [imf_framer_tb.sv]
// Purpose: Self-checking bench for the frame builder
// Assumes: Four links, every link a member while cells flow
// Notes:   Long run at M=32 covers sequence wrap; other sizes briefly
module imf_framer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int L = 4;
    logic             REF_CLK, RST_N, CELL_TICK, USER_VALID, send, pend, chg;
    logic [1:0]       M_CODE;
    logic [L-1:0]     LINK_MEMBER;
    logic [L*5-1:0]   LINK_ID;
    logic [7:0]       USER_DATA, rlabel, eseq, eoff;
    logic [2:0]       rflags, stat, rx_flags;
    logic             USER_READY, rx_valid, TX_VALID;
    logic [7:0]       rx_label, rx_e2e, TX_LABEL, TX_SEQ, TX_OFFSET, TX_FRAME_LEN;
    logic [7:0]       TX_STATUS, TX_UNUSED, TX_E2E;
    logic [L*2-1:0]   TX_KIND;
    logic [L*8-1:0]   TX_USER, TX_OCT7;
    int               num_errors, checks_done, seed, slot, seq, m, ticks, nxt, guard;
    int               off[L];
    logic [4:0]       idl[L];
    logic [1:0]       ek[L];
    logic [7:0]       eu[L];
    logic [7:0]       q[$];
    logic [10:0]      rxt[5] = '{11'h302, 11'h502, 11'h602, 11'h702, 11'h703};

    imf_framer #(.LINKS(L), .QW(8), .QD(4)) imf_framer_inst (
        .REF_CLK(REF_CLK), .RST_N(RST_N), .CELL_TICK(CELL_TICK), .M_CODE(M_CODE),
        .LINK_MEMBER(LINK_MEMBER), .LINK_ID(LINK_ID), .USER_VALID(USER_VALID),
        .USER_READY(USER_READY), .USER_DATA(USER_DATA), .RX_VALID(rx_valid),
        .RX_HEC_OK(rx_flags[2]), .RX_CRC_OK(rx_flags[1]), .RX_IS_CONTROL(rx_flags[0]),
        .RX_LABEL(rx_label), .RX_E2E(rx_e2e), .TX_VALID(TX_VALID), .TX_KIND(TX_KIND),
        .TX_USER(TX_USER), .TX_OCT7(TX_OCT7), .TX_LABEL(TX_LABEL), .TX_SEQ(TX_SEQ),
        .TX_OFFSET(TX_OFFSET), .TX_FRAME_LEN(TX_FRAME_LEN), .TX_STATUS(TX_STATUS),
        .TX_UNUSED(TX_UNUSED), .TX_E2E(TX_E2E));

    imf_far_end imf_far_end_inst (.clk(REF_CLK), .send(send), .flags(rflags),
        .label(rlabel), .rx_valid(rx_valid), .rx_flags(rx_flags), .rx_label(rx_label),
        .rx_e2e(rx_e2e));

    initial begin
        REF_CLK = 1'b0;
        forever #50 REF_CLK = ~REF_CLK;
    end

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        if (num_errors == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // One cycle: check last answer, drive new inputs, predict the answer
    task step(input bit tk, input bit uv);
        bit fu;
        bit acc;
        @(negedge REF_CLK);
        chk(TX_VALID, pend);
        chk(USER_READY, q.size() < 4);
        if (pend) begin
            for (int g = 0; g < L; g++) begin
                chk(TX_KIND[g*2+:2], ek[g]);
                chk(TX_USER[g*8+:8], eu[g]);
                if (ek[g] != imf_pkg::CT_USER) chk(TX_OCT7[g*8+7], ek[g] == 2);
                if (ek[g] == 2 && !(chg && g == 1)) chk(TX_OCT7[g*8+:5], idl[g]);
            end
            chk(TX_SEQ, eseq);
            chk(TX_OFFSET, eoff);
            chk(TX_LABEL, 16'h0003);
            chk(TX_FRAME_LEN, {6'h00, M_CODE});
            chk(TX_STATUS, {5'h00, stat});
            chk({TX_E2E, TX_UNUSED}, 16'h006a);
        end
        CELL_TICK = tk;
        USER_VALID = uv;
        USER_DATA = 8'($random(seed));
        pend = tk;
        acc = uv && q.size() < 4;
        if (tk) begin
            fu = 1'b1;
            for (int g = 0; g < L; g++) begin
                eu[g] = 8'h00;
                ek[g] = imf_pkg::CT_FILLER;
                if (slot == off[g]) begin
                    ek[g] = imf_pkg::CT_CONTROL;
                end else if (fu) begin
                    fu = 1'b0;
                    if (q.size() > 0) begin
                        ek[g] = imf_pkg::CT_USER;
                        eu[g] = q.pop_front();
                    end
                end
            end
            eseq = seq[7:0];
            eoff = slot[7:0];
            slot = (slot + 1) % m;
            if (slot == 0) seq = (seq + 1) % 256;
            ticks++;
        end
        if (acc) q.push_back(USER_DATA);
    endtask

    // Latency of the status update is hidden by two idle cycles
    task rx(input int k);
        {rflags, rlabel} = rxt[k];
        send = 1'b1;
        step(0, 0);
        send = 1'b0;
        repeat (2) step(0, 0);
        if (rflags == 3'h7) stat = (rlabel == 8'h03) ? imf_pkg::STAT_OPERATIONAL
                                                     : imf_pkg::STAT_ABORT_VER;
    endtask

    initial begin
        seed = 32'h8bc82d6e;
        {RST_N, CELL_TICK, USER_VALID, send, pend, chg, M_CODE, LINK_MEMBER} = '0;
        {LINK_ID, USER_DATA, rlabel, rflags} = '0;
        for (int c = 0; c < 4; c++) begin
            M_CODE = c[1:0];
            m = 32 << c;
            RST_N = 1'b0;
            LINK_MEMBER = '0;
            q.delete();
            pend = 1'b0;
            repeat (6) step(0, 0);
            {slot, seq, chg} = '0;
            stat = imf_pkg::STAT_OPERATIONAL;
            RST_N = 1'b1;
            LINK_ID = {5'd31, 5'd16, 5'd8, 5'd0};   // Id 31 puts a cell at 31*M/32, which is M-1 only at M=32
            repeat (2) step(0, 0);
            LINK_MEMBER = 4'hf;
            repeat (2) step(0, 0);
            for (int g = 0; g < L; g++) begin
                idl[g] = LINK_ID[g*5+:5];
                off[g] = (idl[g] * m) >> 5;
            end
            repeat (6) step(0, 1);                  // Overfill the queue
            ticks = 0;
            nxt = m;
            guard = 0;
            while (ticks < m * ((c == 0) ? 258 : 2)) begin
                guard++;
                if (guard > 30000) begin
                    num_errors++;
                    wrap_up();
                end
                if (c == 0 && ticks == nxt) begin
                    nxt += m;
                    if (ticks / m <= 5) rx(ticks / m - 1);
                    if (ticks / m == 6) begin
                        LINK_ID[9:5] = 5'd5;        // Offset must not follow
                        chg = 1'b1;
                    end
                    if (ticks / m == 8) begin
                        LINK_MEMBER[1] = 1'b0;
                        repeat (2) step(0, 0);
                        LINK_MEMBER[1] = 1'b1;
                        repeat (2) step(0, 0);
                        {chg, idl[1], off[1]} = {1'b0, 5'd5, (5 * m) >> 5};
                    end
                end
                step(($random(seed) & 3) != 0, $random(seed) & 1);
            end
        end
        wrap_up();
    end
endmodule
